// ==== shared/qtim_pkg.sv ====
// package: register map, field codes and reset values for the pulse/quadrature timer
// assumes a 32-bit apb slave, one aligned word per register
`default_nettype none
package qtim_pkg;
  localparam logic [11:0] CTRL_OFS = 12'h000;
  localparam logic [11:0] SLAVE_OFS = 12'h004;
  localparam logic [11:0] CHAN_OFS = 12'h008;
  localparam logic [11:0] POL_OFS = 12'h00c;
  localparam logic [11:0] COUNT_OFS = 12'h010;
  localparam logic [11:0] RELOAD_OFS = 12'h014;
  localparam logic [11:0] COMPARE_OFS = 12'h018;
  localparam logic [11:0] STATUS_OFS = 12'h01c;
  // ctrl fields
  localparam int CEN_POS = 0;
  localparam int OPM_POS = 1;
  localparam int DIR_POS = 2;
  localparam int UG_POS = 3;
  // slave fields
  localparam int SMS_POS = 0;
  localparam int TS_POS = 4;
  localparam int ETP_POS = 8;
  localparam int ECE_POS = 9;
  localparam int EXT_TRIGGER_PRESCALE_POS = 10;
  // chan fields
  localparam int CHAN1_SELECTION_POS = 0;
  localparam int CHAN2_SELECTION_POS = 2;
  localparam int OCM_POS = 4;
  localparam int OFE_POS = 7;
  localparam int OCE_POS = 8;
  // polarity fields
  localparam int PA_POS = 0;
  localparam int PB_POS = 1;
  localparam int PAN_POS = 2;
  localparam int PBN_POS = 3;
  // codes
  localparam logic [2:0] SMS_ENC_B = 3'h1;
  localparam logic [2:0] SMS_ENC_A = 3'h2;
  localparam logic [2:0] SMS_ENC_AB = 3'h3;
  localparam logic [2:0] SMS_TRIGGER = 3'h6;
  localparam logic [2:0] TS_FILT_B = 3'h6;
  localparam logic [1:0] SEL_MAP_DIRECT = 2'h1;
  localparam logic [2:0] OCM_PWM1 = 3'h6;
  localparam logic [2:0] OCM_PWM2 = 3'h7;
  localparam logic [15:0] RELOAD_RESET = 16'hffff;
  localparam logic [15:0] ZERO16 = 16'h0000;
  localparam logic [31:0] ZERO32 = 32'h0000_0000;
endpackage
`default_nettype wire

// ==== src/pulse_quad_timer.sv ====
// design: single-pulse / pwm channel, reference clearing and quadrature counter, apb slave
// assumes inputs already synchronous to pclk and filtered upstream
//
// Implementation choices: the APB register port and the register offsets.
`default_nettype none
module pulse_quad_timer #(
  parameter int WIDTH = 16
) (
  // apb
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // encoder and trigger inputs
  input wire logic encoder_input_a,
  input wire logic encoder_input_b,
  input wire logic filtered_ext_trigger,
  // channel output
  output logic channel_reference
);
  logic counter_enable_bit_reg, counter_enable_bit_next;
  logic single_pulse_select_reg, single_pulse_select_next;
  logic dir_reg, dir_next;
  logic [2:0] slave_mode_select_reg, slave_mode_select_next;
  logic [2:0] trigger_source_select_reg, trigger_source_select_next;
  logic ext_trigger_polarity_reg, ext_trigger_polarity_next;
  logic ext_clock2_enable_reg, ext_clock2_enable_next;
  logic [1:0] ext_trigger_prescale_reg, ext_trigger_prescale_next;
  logic [1:0] chan1_selection_reg, chan1_selection_next;
  logic [1:0] chan2_selection_reg, chan2_selection_next;
  logic [2:0] chan1_output_mode_reg, chan1_output_mode_next;
  logic output_fast_enable_reg, output_fast_enable_next;
  logic reference_clear_enable_reg, reference_clear_enable_next;
  logic [3:0] pol_reg, pol_next;
  logic [WIDTH-1:0] counter_value_reg, counter_value_next;
  logic [WIDTH-1:0] auto_reload_value_reg, auto_reload_value_next;
  logic [WIDTH-1:0] compare_value_reg, compare_value_next;
  logic channel_reference_reg, channel_reference_next;
  logic clear_hold_reg, clear_hold_next;
  logic a_prev_reg, a_prev_next;
  logic b_prev_reg, b_prev_next;
  logic [31:0] prdata_reg, prdata_next;

  logic filtered_input_a, filtered_input_b, chan2_pin;
  logic a_edge, b_edge, enc_mode, enc_step, enc_up, trig_edge;
  logic wr, rd, start, update_event, tick, match, at_top, at_bottom, pwm_mode;
  logic [WIDTH-1:0] cnt_step;

  function automatic logic hit(input logic [11:0] a, input logic [11:0] ofs);
    return a == ofs;
  endfunction

  assign wr = psel && penable && pwrite;
  assign rd = psel && !penable && !pwrite;
  assign pready = 1'b1;
  assign pslverr = 1'b0;
  assign prdata = prdata_reg;
  assign channel_reference = channel_reference_reg;

  // polarity adjusted inputs
  assign filtered_input_a = encoder_input_a ^ pol_reg[qtim_pkg::PA_POS];
  assign filtered_input_b = encoder_input_b ^ pol_reg[qtim_pkg::PB_POS];
  assign chan2_pin = (chan2_selection_reg == qtim_pkg::SEL_MAP_DIRECT) && filtered_input_b;
  assign a_edge = filtered_input_a != a_prev_reg;
  assign b_edge = filtered_input_b != b_prev_reg;
  assign enc_mode = slave_mode_select_reg == qtim_pkg::SMS_ENC_B ||
                    slave_mode_select_reg == qtim_pkg::SMS_ENC_A ||
                    slave_mode_select_reg == qtim_pkg::SMS_ENC_AB;
  // trigger: rising edge of mapped input b
  assign trig_edge = (slave_mode_select_reg == qtim_pkg::SMS_TRIGGER) &&
                     (trigger_source_select_reg == qtim_pkg::TS_FILT_B) &&
                     chan2_pin && !b_prev_reg;
  assign pwm_mode = chan1_output_mode_reg == qtim_pkg::OCM_PWM1 ||
                    chan1_output_mode_reg == qtim_pkg::OCM_PWM2;

  always_comb begin
    enc_step = 1'b0;
    enc_up = 1'b0;
    case (slave_mode_select_reg)
      qtim_pkg::SMS_ENC_B: begin
        enc_step = b_edge;
      end
      qtim_pkg::SMS_ENC_A: begin
        enc_step = a_edge;
      end
      qtim_pkg::SMS_ENC_AB: begin
        enc_step = a_edge || b_edge;
      end
      default: begin
        enc_step = 1'b0;
      end
    endcase
    // direction from the edge that moved
    if (a_edge) begin
      enc_up = filtered_input_a ^ filtered_input_b;
    end else if (b_edge) begin
      enc_up = filtered_input_b ~^ filtered_input_a;
    end else begin
      enc_up = !dir_reg;
    end
  end

  assign tick = counter_enable_bit_reg && (enc_mode ? enc_step : 1'b1);
  assign at_top = counter_value_reg == auto_reload_value_reg;
  assign at_bottom = counter_value_reg == qtim_pkg::ZERO16[WIDTH-1:0];
  assign update_event = tick && ((!dir_reg && at_top) || (dir_reg && at_bottom));
  assign cnt_step = dir_reg ? counter_value_reg - 1'b1 : counter_value_reg + 1'b1;
  // look one count ahead so the registered reference lines up with the counter
  assign match = counter_value_next == compare_value_reg;
  assign start = trig_edge && !counter_enable_bit_reg;

  // registers and counter
  always_comb begin
    counter_enable_bit_next = counter_enable_bit_reg;
    single_pulse_select_next = single_pulse_select_reg;
    dir_next = dir_reg;
    slave_mode_select_next = slave_mode_select_reg;
    trigger_source_select_next = trigger_source_select_reg;
    ext_trigger_polarity_next = ext_trigger_polarity_reg;
    ext_clock2_enable_next = ext_clock2_enable_reg;
    ext_trigger_prescale_next = ext_trigger_prescale_reg;
    chan1_selection_next = chan1_selection_reg;
    chan2_selection_next = chan2_selection_reg;
    chan1_output_mode_next = chan1_output_mode_reg;
    output_fast_enable_next = output_fast_enable_reg;
    reference_clear_enable_next = reference_clear_enable_reg;
    pol_next = pol_reg;
    counter_value_next = counter_value_reg;
    auto_reload_value_next = auto_reload_value_reg;
    compare_value_next = compare_value_reg;
    a_prev_next = filtered_input_a;
    b_prev_next = filtered_input_b;
    prdata_next = prdata_reg;
    if (enc_mode && (a_edge || b_edge)) begin
      dir_next = !enc_up;
    end
    if (tick) begin
      if (enc_mode) begin
        if (enc_up) begin
          counter_value_next = at_top ? qtim_pkg::ZERO16[WIDTH-1:0] : counter_value_reg + 1'b1;
        end else begin
          counter_value_next = at_bottom ? auto_reload_value_reg : counter_value_reg - 1'b1;
        end
      end else if (update_event) begin
        counter_value_next = dir_reg ? auto_reload_value_reg : qtim_pkg::ZERO16[WIDTH-1:0];
        if (single_pulse_select_reg) begin
          counter_enable_bit_next = 1'b0;
        end
      end else begin
        counter_value_next = cnt_step;
      end
    end
    if (start) begin
      counter_enable_bit_next = 1'b1;
    end
    if (wr) begin
      if (hit(paddr, qtim_pkg::CTRL_OFS)) begin
        counter_enable_bit_next = pwdata[qtim_pkg::CEN_POS];
        single_pulse_select_next = pwdata[qtim_pkg::OPM_POS];
        dir_next = pwdata[qtim_pkg::DIR_POS];
        if (pwdata[qtim_pkg::UG_POS]) begin
          counter_value_next = pwdata[qtim_pkg::DIR_POS] ? auto_reload_value_reg :
                               qtim_pkg::ZERO16[WIDTH-1:0];
        end
      end
      if (hit(paddr, qtim_pkg::SLAVE_OFS)) begin
        slave_mode_select_next = pwdata[qtim_pkg::SMS_POS +: 3];
        trigger_source_select_next = pwdata[qtim_pkg::TS_POS +: 3];
        ext_trigger_polarity_next = pwdata[qtim_pkg::ETP_POS];
        ext_clock2_enable_next = pwdata[qtim_pkg::ECE_POS];
        ext_trigger_prescale_next = pwdata[qtim_pkg::EXT_TRIGGER_PRESCALE_POS +: 2];
      end
      if (hit(paddr, qtim_pkg::CHAN_OFS)) begin
        chan1_selection_next = pwdata[qtim_pkg::CHAN1_SELECTION_POS +: 2];
        chan2_selection_next = pwdata[qtim_pkg::CHAN2_SELECTION_POS +: 2];
        chan1_output_mode_next = pwdata[qtim_pkg::OCM_POS +: 3];
        output_fast_enable_next = pwdata[qtim_pkg::OFE_POS];
        reference_clear_enable_next = pwdata[qtim_pkg::OCE_POS];
      end
      if (hit(paddr, qtim_pkg::POL_OFS)) begin
        pol_next = pwdata[3:0];
      end
      if (hit(paddr, qtim_pkg::COUNT_OFS)) begin
        counter_value_next = pwdata[WIDTH-1:0];
      end
      if (hit(paddr, qtim_pkg::RELOAD_OFS)) begin
        auto_reload_value_next = pwdata[WIDTH-1:0];
      end
      if (hit(paddr, qtim_pkg::COMPARE_OFS)) begin
        compare_value_next = pwdata[WIDTH-1:0];
      end
    end
    if (rd) begin
      prdata_next = qtim_pkg::ZERO32;
      case (paddr)
        qtim_pkg::CTRL_OFS: begin
          prdata_next[qtim_pkg::CEN_POS] = counter_enable_bit_reg;
          prdata_next[qtim_pkg::OPM_POS] = single_pulse_select_reg;
          prdata_next[qtim_pkg::DIR_POS] = dir_reg;
        end
        qtim_pkg::SLAVE_OFS: begin
          prdata_next[qtim_pkg::SMS_POS +: 3] = slave_mode_select_reg;
          prdata_next[qtim_pkg::TS_POS +: 3] = trigger_source_select_reg;
          prdata_next[qtim_pkg::ETP_POS] = ext_trigger_polarity_reg;
          prdata_next[qtim_pkg::ECE_POS] = ext_clock2_enable_reg;
          prdata_next[qtim_pkg::EXT_TRIGGER_PRESCALE_POS +: 2] = ext_trigger_prescale_reg;
        end
        qtim_pkg::CHAN_OFS: begin
          prdata_next[qtim_pkg::CHAN1_SELECTION_POS +: 2] = chan1_selection_reg;
          prdata_next[qtim_pkg::CHAN2_SELECTION_POS +: 2] = chan2_selection_reg;
          prdata_next[qtim_pkg::OCM_POS +: 3] = chan1_output_mode_reg;
          prdata_next[qtim_pkg::OFE_POS] = output_fast_enable_reg;
          prdata_next[qtim_pkg::OCE_POS] = reference_clear_enable_reg;
        end
        qtim_pkg::POL_OFS: begin
          prdata_next[3:0] = pol_reg;
        end
        qtim_pkg::COUNT_OFS: begin
          prdata_next[WIDTH-1:0] = counter_value_reg;
        end
        qtim_pkg::RELOAD_OFS: begin
          prdata_next[WIDTH-1:0] = auto_reload_value_reg;
        end
        qtim_pkg::COMPARE_OFS: begin
          prdata_next[WIDTH-1:0] = compare_value_reg;
        end
        qtim_pkg::STATUS_OFS: begin
          prdata_next[0] = channel_reference_reg;
          prdata_next[1] = clear_hold_reg;
          prdata_next[2] = filtered_input_a;
          prdata_next[3] = filtered_input_b;
        end
        default: begin
          prdata_next = qtim_pkg::ZERO32;
        end
      endcase
    end
  end

  // channel reference
  always_comb begin
    channel_reference_next = channel_reference_reg;
    clear_hold_next = clear_hold_reg;
    if (chan1_output_mode_reg == qtim_pkg::OCM_PWM2) begin
      if (match && counter_enable_bit_reg) begin
        channel_reference_next = 1'b1;
      end
      if (update_event || (!counter_enable_bit_reg && !start)) begin
        channel_reference_next = compare_value_reg > auto_reload_value_reg;
      end
    end else if (chan1_output_mode_reg == qtim_pkg::OCM_PWM1) begin
      channel_reference_next = counter_value_reg < compare_value_reg;
    end else begin
      channel_reference_next = 1'b0;
    end
    if (start && output_fast_enable_reg && pwm_mode) begin
      channel_reference_next = chan1_output_mode_reg != qtim_pkg::OCM_PWM1;
    end
    if (update_event) begin
      clear_hold_next = 1'b0;
    end
    if (reference_clear_enable_reg && filtered_ext_trigger) begin
      clear_hold_next = 1'b1;
    end
    if (clear_hold_next) begin
      channel_reference_next = 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      counter_enable_bit_reg <= 1'b0;
      single_pulse_select_reg <= 1'b0;
      dir_reg <= 1'b0;
      slave_mode_select_reg <= 3'h0;
      trigger_source_select_reg <= 3'h0;
      ext_trigger_polarity_reg <= 1'b0;
      ext_clock2_enable_reg <= 1'b0;
      ext_trigger_prescale_reg <= 2'h0;
      chan1_selection_reg <= 2'h0;
      chan2_selection_reg <= 2'h0;
      chan1_output_mode_reg <= 3'h0;
      output_fast_enable_reg <= 1'b0;
      reference_clear_enable_reg <= 1'b0;
      pol_reg <= 4'h0;
      counter_value_reg <= '0;
      auto_reload_value_reg <= qtim_pkg::RELOAD_RESET[WIDTH-1:0];
      compare_value_reg <= '0;
      channel_reference_reg <= 1'b0;
      clear_hold_reg <= 1'b0;
      a_prev_reg <= 1'b0;
      b_prev_reg <= 1'b0;
      prdata_reg <= qtim_pkg::ZERO32;
    end else begin
      counter_enable_bit_reg <= counter_enable_bit_next;
      single_pulse_select_reg <= single_pulse_select_next;
      dir_reg <= dir_next;
      slave_mode_select_reg <= slave_mode_select_next;
      trigger_source_select_reg <= trigger_source_select_next;
      ext_trigger_polarity_reg <= ext_trigger_polarity_next;
      ext_clock2_enable_reg <= ext_clock2_enable_next;
      ext_trigger_prescale_reg <= ext_trigger_prescale_next;
      chan1_selection_reg <= chan1_selection_next;
      chan2_selection_reg <= chan2_selection_next;
      chan1_output_mode_reg <= chan1_output_mode_next;
      output_fast_enable_reg <= output_fast_enable_next;
      reference_clear_enable_reg <= reference_clear_enable_next;
      pol_reg <= pol_next;
      counter_value_reg <= counter_value_next;
      auto_reload_value_reg <= auto_reload_value_next;
      compare_value_reg <= compare_value_next;
      channel_reference_reg <= channel_reference_next;
      clear_hold_reg <= clear_hold_next;
      a_prev_reg <= a_prev_next;
      b_prev_reg <= b_prev_next;
      prdata_reg <= prdata_next;
    end
  end

  // checks
  a_opm_stop: assert property (@(posedge pclk) disable iff (!presetn)
    update_event && single_pulse_select_reg && !enc_mode && !start && !wr
    |=> !counter_enable_bit_reg) else $error("single pulse did not stop");
  a_trig_start: assert property (@(posedge pclk) disable iff (!presetn)
    start && !wr |=> counter_enable_bit_reg) else $error("trigger did not start counter");
  a_fast_force: assert property (@(posedge pclk) disable iff (!presetn)
    start && output_fast_enable_reg && chan1_output_mode_reg == qtim_pkg::OCM_PWM2 &&
    !clear_hold_next |=> channel_reference_reg) else $error("fast enable did not force");
  a_clear_low: assert property (@(posedge pclk) disable iff (!presetn)
    reference_clear_enable_reg && filtered_ext_trigger |=> !channel_reference_reg)
    else $error("reference not cleared");
  a_enc_wrap_up: assert property (@(posedge pclk) disable iff (!presetn)
    enc_mode && tick && enc_up && at_top && !wr |=> counter_value_reg == '0)
    else $error("encoder up wrap wrong");
  a_enc_wrap_dn: assert property (@(posedge pclk) disable iff (!presetn)
    enc_mode && tick && !enc_up && at_bottom && !wr
    |=> counter_value_reg == $past(auto_reload_value_reg)) else $error("encoder down wrap wrong");
  a_enc_hold_b: assert property (@(posedge pclk) disable iff (!presetn)
    slave_mode_select_reg == qtim_pkg::SMS_ENC_B && !b_edge && !wr
    |=> $stable(counter_value_reg)) else $error("b-only mode counted");
  a_enc_gate: assert property (@(posedge pclk) disable iff (!presetn)
    enc_mode && !counter_enable_bit_reg && !wr |=> $stable(counter_value_reg))
    else $error("encoder counted while disabled");
endmodule
`default_nettype wire

// ==== verif/pulse_quad_timer_tb.sv ====
// testbench: apb sequences for single pulse, reference clearing and encoder counting
// assumes the encoder model drives the a/b lines and the external trigger
`default_nettype none
module pulse_quad_timer_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic enc_a;
  logic enc_b;
  logic ext_trig;
  logic channel_reference;
  int n_mismatch = 0;
  int num_checks = 0;
  int t_rise;
  int n_hi;
  int n;
  logic [2:0] modes [3] = '{qtim_pkg::SMS_ENC_B, qtim_pkg::SMS_ENC_A, qtim_pkg::SMS_ENC_AB};
  logic [31:0] exp_cnt [3] = '{32'h0000_0002, 32'h0000_0002, 32'h0000_0004};
  logic [31:0] chan_v;
  always #2 pclk = ~pclk;
  pulse_quad_timer #(.WIDTH(16)) u_pulse_quad_timer (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .encoder_input_a(enc_a), .encoder_input_b(enc_b), .filtered_ext_trigger(ext_trig),
    .channel_reference(channel_reference)
  );
  quad_enc_model u_quad_enc_model (
    .pclk(pclk), .presetn(presetn), .enc_a(enc_a), .enc_b(enc_b), .ext_trig(ext_trig)
  );
  task automatic results();
    if (n_mismatch == 0 && num_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic xfer(input logic [11:0] a, input logic w, input logic [31:0] d,
                      output logic [31:0] r);
    int k;
    k = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'b1 && k < 20);
    r = prdata;
    num_checks++;
    if (pslverr !== 1'b0) begin
      n_mismatch++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, pslverr, 1'b0);
    end
    if (pready !== 1'b1) begin
      n_mismatch++;
      results();
    end
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] r;
    xfer(a, 1'b1, d, r);
  endtask
  task automatic rdc(input logic [11:0] a, input logic [31:0] exp);
    logic [31:0] r;
    xfer(a, 1'b0, 32'h0000_0000, r);
    chk(r, exp);
  endtask
  // count high cycles of the reference over 40 edges, noting the first
  task automatic watch();
    t_rise = -1;
    n_hi = 0;
    for (int i = 0; i < 40; i++) begin
      @(posedge pclk);
      if (channel_reference === 1'b1) begin
        if (n_hi == 0) t_rise = i;
        n_hi++;
      end
    end
  endtask
  initial begin
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rdc(qtim_pkg::RELOAD_OFS, {16'h0000, qtim_pkg::RELOAD_RESET});
    rdc(qtim_pkg::COUNT_OFS, qtim_pkg::ZERO32);
    rdc(qtim_pkg::CTRL_OFS, qtim_pkg::ZERO32);
    wr(12'h020, 32'hffff_ffff);
    rdc(12'h020, qtim_pkg::ZERO32);
    // encoder modes, fast stepping
    chan_v = (32'(qtim_pkg::SEL_MAP_DIRECT) << qtim_pkg::CHAN1_SELECTION_POS)
           | (32'(qtim_pkg::SEL_MAP_DIRECT) << qtim_pkg::CHAN2_SELECTION_POS);
    wr(qtim_pkg::CHAN_OFS, chan_v);
    wr(qtim_pkg::POL_OFS, qtim_pkg::ZERO32);
    wr(qtim_pkg::RELOAD_OFS, 32'h0000_00ff);
    u_quad_enc_model.gap = 1;
    for (int i = 0; i < 3; i++) begin
      wr(qtim_pkg::SLAVE_OFS, {29'h0, modes[i]});
      wr(qtim_pkg::COUNT_OFS, qtim_pkg::ZERO32);
      wr(qtim_pkg::CTRL_OFS, 32'h0000_0001);
      repeat (4) u_quad_enc_model.step(1'b0);
      rdc(qtim_pkg::COUNT_OFS, exp_cnt[i]);
    end
    wr(qtim_pkg::CTRL_OFS, qtim_pkg::ZERO32);
    repeat (4) u_quad_enc_model.step(1'b0);
    rdc(qtim_pkg::COUNT_OFS, 32'h0000_0004);
    // wrap both ways, slow stepping
    u_quad_enc_model.gap = 4;
    wr(qtim_pkg::RELOAD_OFS, 32'h0000_0003);
    wr(qtim_pkg::COUNT_OFS, qtim_pkg::ZERO32);
    wr(qtim_pkg::CTRL_OFS, 32'h0000_0001);
    repeat (5) u_quad_enc_model.step(1'b0);
    rdc(qtim_pkg::COUNT_OFS, 32'h0000_0001);
    repeat (2) u_quad_enc_model.step(1'b1);
    rdc(qtim_pkg::COUNT_OFS, 32'h0000_0003);
    rdc(qtim_pkg::CTRL_OFS, 32'h0000_0005);
    // single pulse started by rising b
    u_quad_enc_model.set_lines(1'b0, 1'b0);
    wr(qtim_pkg::CTRL_OFS, qtim_pkg::ZERO32);
    wr(qtim_pkg::SLAVE_OFS, (32'(qtim_pkg::TS_FILT_B) << qtim_pkg::TS_POS)
       | 32'(qtim_pkg::SMS_TRIGGER));
    wr(qtim_pkg::CHAN_OFS, chan_v | (32'(qtim_pkg::OCM_PWM2) << qtim_pkg::OCM_POS));
    wr(qtim_pkg::RELOAD_OFS, 32'h0000_0006);
    wr(qtim_pkg::COMPARE_OFS, 32'h0000_0003);
    wr(qtim_pkg::COUNT_OFS, qtim_pkg::ZERO32);
    wr(qtim_pkg::CTRL_OFS, 32'h0000_0002);
    fork
      u_quad_enc_model.set_lines(1'b0, 1'b1);
      watch();
    join
    chk(32'(n_hi), 32'h0000_0004);
    chk(32'(t_rise >= 3 && t_rise <= 9), 32'h0000_0001);
    rdc(qtim_pkg::CTRL_OFS, 32'h0000_0002);
    rdc(qtim_pkg::COUNT_OFS, qtim_pkg::ZERO32);
    // fast enable, in pwm2 and then in frozen mode
    wr(qtim_pkg::RELOAD_OFS, 32'h0000_000c);
    wr(qtim_pkg::COMPARE_OFS, 32'h0000_000a);
    for (int i = 0; i < 2; i++) begin
      u_quad_enc_model.set_lines(1'b0, 1'b0);
      wr(qtim_pkg::CHAN_OFS, chan_v | (32'h1 << qtim_pkg::OFE_POS)
         | (i == 0 ? 32'(qtim_pkg::OCM_PWM2) << qtim_pkg::OCM_POS : 32'h0000_0000));
      wr(qtim_pkg::COUNT_OFS, qtim_pkg::ZERO32);
      wr(qtim_pkg::CTRL_OFS, 32'h0000_0002);
      fork
        u_quad_enc_model.set_lines(1'b0, 1'b1);
        watch();
      join
      if (i == 0) chk(32'(t_rise >= 0 && t_rise < 10), 32'h0000_0001);
      else chk(32'(n_hi), qtim_pkg::ZERO32);
      rdc(qtim_pkg::CTRL_OFS, 32'h0000_0002);
    end
    // full duty reference cleared by the trigger line
    wr(qtim_pkg::SLAVE_OFS, qtim_pkg::ZERO32);
    wr(qtim_pkg::CHAN_OFS, (32'(qtim_pkg::OCM_PWM1) << qtim_pkg::OCM_POS)
       | (32'h1 << qtim_pkg::OCE_POS));
    wr(qtim_pkg::RELOAD_OFS, 32'h0000_003f);
    wr(qtim_pkg::COMPARE_OFS, 32'h0000_0080);
    wr(qtim_pkg::COUNT_OFS, qtim_pkg::ZERO32);
    wr(qtim_pkg::CTRL_OFS, 32'h0000_0001);
    chk({31'h0, channel_reference}, 32'h0000_0001);
    u_quad_enc_model.pulse_ext();
    @(posedge pclk);
    chk({31'h0, channel_reference}, qtim_pkg::ZERO32);
    n = 0;
    while (channel_reference !== 1'b1 && n < 100) begin
      @(posedge pclk);
      n++;
    end
    chk(32'(n > 40 && n < 100), 32'h0000_0001);
    rdc(qtim_pkg::CTRL_OFS, 32'h0000_0001);
    results();
  end
endmodule
`default_nettype wire

// ==== verif/quad_enc_model.sv ====
// partner: incremental quadrature encoder plus external trigger source
// assumes the bench calls its tasks from one thread, right after a pclk edge
`default_nettype none
module quad_enc_model (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // encoder lines and trigger
  output logic enc_a,
  output logic enc_b,
  output logic ext_trig
);
  timeunit 1ns;
  timeprecision 1ps;
  int gap = 3;
  logic [1:0] phase = 2'h0;
  initial begin
    enc_a = 1'b0;
    enc_b = 1'b0;
    ext_trig = 1'b0;
  end
  // drive both lines at one edge, then rest gap cycles
  task automatic set_lines(input logic a, input logic b);
    @(posedge pclk);
    enc_a <= a;
    enc_b <= b;
    repeat (gap) @(posedge pclk);
  endtask
  // one gray step: only one line changes at a time
  task automatic step(input logic back);
    phase = back ? phase - 2'h1 : phase + 2'h1;
    set_lines(phase[0] ^ phase[1], phase[1]);
  endtask
  // one-cycle high pulse on the trigger line
  task automatic pulse_ext();
    @(posedge pclk);
    ext_trig <= 1'b1;
    @(posedge pclk);
    ext_trig <= 1'b0;
  endtask
endmodule
`default_nettype wire
